// ---- logic/ttc_cfg.svh ----
// Register offsets, field positions, reset values and timing counts of the timer unit
`ifndef TTC_CFG_SVH
`define TTC_CFG_SVH

`define TTC_OFF_TIMER_CONTROL_REGISTER      4'h0
`define TTC_OFF_TIMER_MODE_REGISTER      4'h1
`define TTC_OFF_TL0       4'h2
`define TTC_OFF_TH0       4'h3
`define TTC_OFF_TL1       4'h4
`define TTC_OFF_TH1       4'h5
`define TTC_OFF_TIMER2_CONTROL     4'h6
`define TTC_OFF_TL2       4'h7
`define TTC_OFF_TH2       4'h8
`define TTC_OFF_CAPL      4'h9
`define TTC_OFF_CAPH      4'ha
`define TTC_OFF_LAST      4'ha

`define TTC_TIMER_CONTROL_REGISTER_TF1      7
`define TTC_TIMER_CONTROL_REGISTER_TR1      6
`define TTC_TIMER_CONTROL_REGISTER_TF0      5
`define TTC_TIMER_CONTROL_REGISTER_TR0      4

`define TTC_TIMER_MODE_REGISTER_GATE1    7
`define TTC_TIMER_MODE_REGISTER_CT1      6
`define TTC_TIMER_MODE_REGISTER_M1_HI    5
`define TTC_TIMER_MODE_REGISTER_M1_LO    4
`define TTC_TIMER_MODE_REGISTER_GATE0    3
`define TTC_TIMER_MODE_REGISTER_CT0      2
`define TTC_TIMER_MODE_REGISTER_M0_HI    1
`define TTC_TIMER_MODE_REGISTER_M0_LO    0

`define TTC_T2_TF2        7
`define TTC_T2_TIMER2_EXTERNAL_FLAG       6
`define TTC_T2_RCLK       5
`define TTC_T2_SERIAL_TX_CLOCK_SELECT       4
`define TTC_T2_TIMER2_EXTERNAL_ENABLE      3
`define TTC_T2_TR2        2
`define TTC_T2_CT2        1
`define TTC_T2_CPRL2      0

`define TTC_RST_BYTE      8'h00
`define TTC_RST_WORD      32'h0000_0000

`define TTC_OSC_PER_MC    12
`define TTC_MC_LAST       4'(`TTC_OSC_PER_MC - 1)

`define TTC_PIN_CNT0      0
`define TTC_PIN_CNT1      1
`define TTC_PIN_CNT2      2
`define TTC_PIN_GATE0     3
`define TTC_PIN_GATE1     4
`define TTC_PIN_TRIG      5
`define TTC_NPINS         6

`endif

// ---- logic/ttc_pkg.sv ----
// Types shared by the timer unit
package ttc_pkg;

  typedef enum logic [3:0] {
    TTC_M13   = 4'b0001,
    TTC_M16   = 4'b0010,
    TTC_M8RL  = 4'b0100,
    TTC_SPLIT = 4'b1000
  } ttc_mode_t;

  typedef struct packed {
    logic       ovf;
    logic [7:0] th;
    logic [7:0] tl;
  } ttc_cnt_t;

endpackage

// ---- logic/ttc_top.sv ----
// Three timer/counters with an APB register slave
//
// What this block does
// [R1] Timer function counts one per machine cycle of twelve clocks.
// [R2] Counter pins sampled each machine cycle; high-then-low counts next cycle.
// [R3] Edge detection spans two machine cycles, so events max at clk/24.
// [R4] External source holds each count level at least one machine cycle.
// [R5] Mode 0 is 13 bits: high byte plus low five bits of low byte.
// [R6] Timer 0/1 counts only with run set and gate clear or gate pin high.
// [R7] Gate bits sit at mode register bit 7 (timer 1) and bit 3 (timer 0).
// [R8] Setting a run bit leaves the count as it is.
// [R9] Mode 1 counts 16 bits, flags wrap to zero, keeps counting.
// [R10] Mode 2 low byte counts, reloads from high byte on overflow, flags.
// [R11] Timer 1 in mode 3 holds its count as if stopped.
// [R12] Timer 0 mode 3: low byte own counter; high byte timer using timer 1 run/flag.
// [R13] With timer 0 split, timer 1 runs outside mode 3 and still feeds baud.
// [R14] Each timer's mode comes from two mode bits; function from a select bit.
// [R15] Timer 2 counts machine cycles or falling count-pin edges per select bit.
// [R16] Timer 2 runs only while its run bit is set.
// [R17] Capture mode: 16-bit count whose overflow sets the timer 2 overflow flag.
// [R18] Capture mode with external enable: trigger fall copies count, sets external flag.
// [R19] Reload mode: overflow sets flag and reloads 16 bits from capture registers.
// [R20] Reload mode with external enable: trigger fall also reloads, sets external flag.
// [R21] External enable clear: trigger pin events are ignored.
// [R22] Any serial clock select puts timer 2 in baud mode, always reloading.
// [R23] Flags set by hardware, cleared by software; no overflow flag in baud mode.
// [R24] Receive/transmit clock selects pick timer 2 (1) or timer 1 (0) overflow.
//
// The address map and the APB slave port were left to the implementer.
`include "ttc_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module ttc_top
  import ttc_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  input  wire logic              count_pin_zero,
  input  wire logic              count_pin_one,
  input  wire logic              count_pin_two,
  input  wire logic              gate_pin_zero,
  input  wire logic              gate_pin_one,
  input  wire logic              timer2_trigger_pin,
  output var  logic              serial_rx_baud_tick,
  output var  logic              serial_tx_baud_tick
);

  logic [3:0]           mc_cnt_reg;
  logic                 mc_tick;
  logic [`TTC_NPINS-1:0] pins;
  logic [`TTC_NPINS-1:0] sync1_reg;
  logic [`TTC_NPINS-1:0] sync2_reg;
  logic [`TTC_NPINS-1:0] smp_reg;
  logic [`TTC_NPINS-1:0] fall_reg;
  logic [`TTC_NPINS-1:0] ev;

  logic [7:0] timer_mode_register_reg;
  logic       tr0_reg;
  logic       tr1_reg;
  logic       tf0_reg;
  logic       tf1_reg;
  logic [7:0] tl0_reg;
  logic [7:0] th0_reg;
  logic [7:0] tl1_reg;
  logic [7:0] th1_reg;
  logic       tf2_reg;
  logic       timer2_external_flag_reg;
  logic       rclk_reg;
  logic       serial_tx_clock_select_reg;
  logic       timer2_external_enable_reg;
  logic       tr2_reg;
  logic       ct2_reg;
  logic       cprl2_reg;
  logic [7:0] tl2_reg;
  logic [7:0] th2_reg;
  logic [7:0] capl_reg;
  logic [7:0] caph_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        baud_rx_reg;
  logic        baud_tx_reg;

  // Machine cycle prescaler
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mc_cnt_reg <= 4'h0;
    end else if (mc_cnt_reg == `TTC_MC_LAST) begin
      mc_cnt_reg <= 4'h0;
    end else begin
      mc_cnt_reg <= mc_cnt_reg + 4'h1;
    end
  end
  assign mc_tick = (mc_cnt_reg == `TTC_MC_LAST); // [R1]

  assign pins = {timer2_trigger_pin, gate_pin_one, gate_pin_zero,
                 count_pin_two, count_pin_one, count_pin_zero};

  // Pin synchroniser
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg; // [R4]
    end
  end

  // Once-per-machine-cycle sampling and falling edge detection
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      smp_reg  <= '0;
      fall_reg <= '0;
    end else if (mc_tick) begin
      smp_reg  <= sync2_reg; // [R2]
      fall_reg <= smp_reg & ~sync2_reg; // [R3]
    end
  end
  assign ev = fall_reg & {`TTC_NPINS{mc_tick}}; // [R2]

  // One counting step of a timer 0/1 in the given mode
  function automatic ttc_cnt_t step(input ttc_mode_t m, input logic [7:0] tl,
                                    input logic [7:0] th, input logic en);
    ttc_cnt_t r;
    logic [13:0] s13;
    logic [16:0] s16;
    logic [8:0]  s8;
    r   = '{ovf: 1'b0, th: th, tl: tl};
    s13 = {1'b0, th, tl[4:0]} + 14'h1;
    s16 = {1'b0, th, tl} + 17'h1;
    s8  = {1'b0, tl} + 9'h1;
    if (en) begin
      case (m)
        TTC_M13: begin
          r.ovf = s13[13]; // [R5]
          r.th  = s13[12:5];
          r.tl  = {tl[7:5], s13[4:0]}; // [R5]
        end
        TTC_M16: begin
          r.ovf = s16[16]; // [R9]
          r.th  = s16[15:8];
          r.tl  = s16[7:0];
        end
        TTC_M8RL: begin
          r.ovf = s8[8];
          r.tl  = s8[8] ? th : s8[7:0]; // [R10]
        end
        TTC_SPLIT: begin
          r.ovf = s8[8];
          r.tl  = s8[7:0];
        end
        default: begin
          r.ovf = 1'b0;
        end
      endcase
    end
    return r;
  endfunction

  function automatic ttc_mode_t dec_mode(input logic [1:0] b);
    case (b)
      2'd0:    dec_mode = TTC_M13;
      2'd1:    dec_mode = TTC_M16;
      2'd2:    dec_mode = TTC_M8RL;
      default: dec_mode = TTC_SPLIT;
    endcase
  endfunction

  ttc_mode_t mode0;
  ttc_mode_t mode1;
  logic      en0;
  logic      en1;
  logic      en_th0;
  logic      split0;
  ttc_cnt_t  r0;
  ttc_cnt_t  r1;
  logic [8:0] th0_s;

  assign mode0  = dec_mode(timer_mode_register_reg[`TTC_TIMER_MODE_REGISTER_M0_HI:`TTC_TIMER_MODE_REGISTER_M0_LO]); // [R14]
  assign mode1  = dec_mode(timer_mode_register_reg[`TTC_TIMER_MODE_REGISTER_M1_HI:`TTC_TIMER_MODE_REGISTER_M1_LO]); // [R14]
  assign split0 = (mode0 == TTC_SPLIT);
  assign en0 = tr0_reg & (~timer_mode_register_reg[`TTC_TIMER_MODE_REGISTER_GATE0] | sync2_reg[`TTC_PIN_GATE0]) & // [R6] [R7]
               (timer_mode_register_reg[`TTC_TIMER_MODE_REGISTER_CT0] ? ev[`TTC_PIN_CNT0] : mc_tick); // [R14]
  assign en1 = tr1_reg & (~timer_mode_register_reg[`TTC_TIMER_MODE_REGISTER_GATE1] | sync2_reg[`TTC_PIN_GATE1]) & // [R6] [R7]
               (timer_mode_register_reg[`TTC_TIMER_MODE_REGISTER_CT1] ? ev[`TTC_PIN_CNT1] : mc_tick) &
               (mode1 != TTC_SPLIT); // [R11] [R13]
  assign en_th0 = split0 & tr1_reg & mc_tick; // [R12]
  assign r0     = step(mode0, tl0_reg, th0_reg, en0);
  assign r1     = step(mode1, tl1_reg, th1_reg, en1);
  assign th0_s  = {1'b0, th0_reg} + {8'h00, en_th0};

  // APB decode
  logic       wr;
  logic [3:0] idx;
  logic       hit;
  assign idx = paddr[5:2];
  assign hit = (paddr[ADDR_W-1:6] == '0) && (paddr[1:0] == 2'b00) && (idx <= `TTC_OFF_LAST);
  assign wr  = psel & penable & pready_reg & pwrite & hit;

  function automatic logic wsel(input logic w, input logic [3:0] i, input logic [3:0] o);
    return w && (i == o);
  endfunction

  // Timer 0 count bytes; software writes win over counting
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tl0_reg <= `TTC_RST_BYTE;
      th0_reg <= `TTC_RST_BYTE;
    end else begin
      tl0_reg <= wsel(wr, idx, `TTC_OFF_TL0) ? pwdata[7:0] : r0.tl; // [R8]
      if (wsel(wr, idx, `TTC_OFF_TH0)) begin
        th0_reg <= pwdata[7:0];
      end else if (split0) begin
        th0_reg <= th0_s[7:0]; // [R12]
      end else begin
        th0_reg <= r0.th;
      end
    end
  end

  // Timer 1 count bytes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tl1_reg <= `TTC_RST_BYTE;
      th1_reg <= `TTC_RST_BYTE;
    end else begin
      tl1_reg <= wsel(wr, idx, `TTC_OFF_TL1) ? pwdata[7:0] : r1.tl; // [R8]
      th1_reg <= wsel(wr, idx, `TTC_OFF_TH1) ? pwdata[7:0] : r1.th;
    end
  end

  // Mode register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      timer_mode_register_reg <= `TTC_RST_BYTE;
    end else if (wsel(wr, idx, `TTC_OFF_TIMER_MODE_REGISTER)) begin
      timer_mode_register_reg <= pwdata[7:0];
    end
  end

  // Timer 0/1 run bits and overflow flags; hardware set wins over a write
  logic set_tf0;
  logic set_tf1;
  logic wr_timer_control_register;
  assign set_tf0 = r0.ovf; // [R12]
  assign set_tf1 = split0 ? th0_s[8] : r1.ovf; // [R12] [R13]
  assign wr_timer_control_register = wsel(wr, idx, `TTC_OFF_TIMER_CONTROL_REGISTER);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tr0_reg <= 1'b0;
      tr1_reg <= 1'b0;
      tf0_reg <= 1'b0;
      tf1_reg <= 1'b0;
    end else begin
      if (wr_timer_control_register) begin
        tr0_reg <= pwdata[`TTC_TIMER_CONTROL_REGISTER_TR0];
        tr1_reg <= pwdata[`TTC_TIMER_CONTROL_REGISTER_TR1];
      end
      tf0_reg <= set_tf0 | (wr_timer_control_register ? pwdata[`TTC_TIMER_CONTROL_REGISTER_TF0] : tf0_reg); // [R23]
      tf1_reg <= set_tf1 | (wr_timer_control_register ? pwdata[`TTC_TIMER_CONTROL_REGISTER_TF1] : tf1_reg); // [R23]
    end
  end

  // Timer 2
  logic        baud2;
  logic        en2;
  logic [16:0] s2;
  logic        ovf2;
  logic        trig2;
  logic        cap2;
  logic        rld2;
  logic        wr_timer2_control;
  assign baud2 = rclk_reg | serial_tx_clock_select_reg; // [R22]
  assign en2   = tr2_reg & (ct2_reg ? ev[`TTC_PIN_CNT2] : mc_tick); // [R15] [R16]
  assign s2    = {1'b0, th2_reg, tl2_reg} + {16'h0000, en2};
  assign ovf2  = s2[16]; // [R17]
  assign trig2 = timer2_external_enable_reg & ev[`TTC_PIN_TRIG]; // [R21]
  assign cap2  = trig2 & cprl2_reg & ~baud2; // [R18]
  assign rld2  = (ovf2 & (~cprl2_reg | baud2)) | (trig2 & ~cprl2_reg & ~baud2); // [R19] [R20] [R22]
  assign wr_timer2_control = wsel(wr, idx, `TTC_OFF_TIMER2_CONTROL);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tl2_reg <= `TTC_RST_BYTE;
      th2_reg <= `TTC_RST_BYTE;
    end else begin
      if (wsel(wr, idx, `TTC_OFF_TL2)) begin
        tl2_reg <= pwdata[7:0];
      end else begin
        tl2_reg <= rld2 ? capl_reg : s2[7:0]; // [R19]
      end
      if (wsel(wr, idx, `TTC_OFF_TH2)) begin
        th2_reg <= pwdata[7:0];
      end else begin
        th2_reg <= rld2 ? caph_reg : s2[15:8]; // [R19]
      end
    end
  end

  // Capture/reload value registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      capl_reg <= `TTC_RST_BYTE;
      caph_reg <= `TTC_RST_BYTE;
    end else begin
      if (wsel(wr, idx, `TTC_OFF_CAPL)) begin
        capl_reg <= pwdata[7:0];
      end else if (cap2) begin
        capl_reg <= tl2_reg; // [R18]
      end
      if (wsel(wr, idx, `TTC_OFF_CAPH)) begin
        caph_reg <= pwdata[7:0];
      end else if (cap2) begin
        caph_reg <= th2_reg; // [R18]
      end
    end
  end

  // Timer 2 control register and its flags
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tf2_reg   <= 1'b0;
      timer2_external_flag_reg  <= 1'b0;
      rclk_reg  <= 1'b0;
      serial_tx_clock_select_reg  <= 1'b0;
      timer2_external_enable_reg <= 1'b0;
      tr2_reg   <= 1'b0;
      ct2_reg   <= 1'b0;
      cprl2_reg <= 1'b0;
    end else begin
      if (wr_timer2_control) begin
        rclk_reg  <= pwdata[`TTC_T2_RCLK];
        serial_tx_clock_select_reg  <= pwdata[`TTC_T2_SERIAL_TX_CLOCK_SELECT];
        timer2_external_enable_reg <= pwdata[`TTC_T2_TIMER2_EXTERNAL_ENABLE];
        tr2_reg   <= pwdata[`TTC_T2_TR2];
        ct2_reg   <= pwdata[`TTC_T2_CT2];
        cprl2_reg <= pwdata[`TTC_T2_CPRL2];
      end
      tf2_reg  <= (ovf2 & ~baud2) | (wr_timer2_control ? pwdata[`TTC_T2_TF2] : tf2_reg); // [R17] [R23]
      timer2_external_flag_reg <= trig2 | (wr_timer2_control ? pwdata[`TTC_T2_TIMER2_EXTERNAL_FLAG] : timer2_external_flag_reg); // [R18] [R20] [R23]
    end
  end

  // Serial clock source selection
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      baud_rx_reg <= 1'b0;
      baud_tx_reg <= 1'b0;
    end else begin
      baud_rx_reg <= rclk_reg ? ovf2 : r1.ovf; // [R24] [R13]
      baud_tx_reg <= serial_tx_clock_select_reg ? ovf2 : r1.ovf; // [R24]
    end
  end

  // Read mux
  logic [7:0] rd_byte;
  always_comb begin
    case (idx)
      `TTC_OFF_TIMER_CONTROL_REGISTER:  rd_byte = {tf1_reg, tr1_reg, tf0_reg, tr0_reg, 4'h0};
      `TTC_OFF_TIMER_MODE_REGISTER:  rd_byte = timer_mode_register_reg;
      `TTC_OFF_TL0:   rd_byte = tl0_reg;
      `TTC_OFF_TH0:   rd_byte = th0_reg;
      `TTC_OFF_TL1:   rd_byte = tl1_reg;
      `TTC_OFF_TH1:   rd_byte = th1_reg;
      `TTC_OFF_TIMER2_CONTROL: rd_byte = {tf2_reg, timer2_external_flag_reg, rclk_reg, serial_tx_clock_select_reg,
                                 timer2_external_enable_reg, tr2_reg, ct2_reg, cprl2_reg};
      `TTC_OFF_TL2:   rd_byte = tl2_reg;
      `TTC_OFF_TH2:   rd_byte = th2_reg;
      `TTC_OFF_CAPL:  rd_byte = capl_reg;
      `TTC_OFF_CAPH:  rd_byte = caph_reg;
      default:        rd_byte = 8'h00;
    endcase
  end

  // APB answer: ready in the first access cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= `TTC_RST_WORD;
    end else begin
      pready_reg  <= psel & ~penable;
      pslverr_reg <= psel & ~penable & ~hit;
      if (psel & ~penable) begin
        prdata_reg <= (hit & ~pwrite) ? {24'h000000, rd_byte} : `TTC_RST_WORD;
      end
    end
  end

  assign prdata              = prdata_reg;
  assign pready              = pready_reg;
  assign pslverr             = pslverr_reg;
  assign serial_rx_baud_tick = baud_rx_reg;
  assign serial_tx_baud_tick = baud_tx_reg;

endmodule

`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench for the timer unit
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        clk;
  logic        rstn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        gate0;
  logic        gate1;
  logic        rx_tick;
  logic        tx_tick;
  wire logic   cnt;
  wire logic   trig;
  logic [31:0] rdv;
  logic        rer;
  logic [7:0]  r;
  int          n_mismatch;
  int          comparisons;
  int          rxn;
  int          txn;
  int          rx0;
  int          tx0;

  ttc_top u_dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .count_pin_zero(cnt), .count_pin_one(cnt), .count_pin_two(cnt), .gate_pin_zero(gate0),
    .gate_pin_one(gate1), .timer2_trigger_pin(trig), .serial_rx_baud_tick(rx_tick),
    .serial_tx_baud_tick(tx_tick));
  ttc_pins u_src (.clk(clk), .cnt(cnt), .trig(trig));

  always #5 clk = ~clk;
  always @(posedge clk) begin
    rxn <= rxn + int'(rx_tick);
    txn <= txn + int'(tx_tick);
  end

  task automatic conclude();
    if (n_mismatch == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    if (k == 20) begin
      n_mismatch++;
      conclude();
    end else begin
      rdv = prdata;
      rer = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdv, exp);
  endtask
  // Expected timer control read: flags and run bits in the high nibble
  function automatic logic [31:0] timer_control_register(input bit f1, input bit r1, input bit f0, input bit r0);
    return {24'h0, f1, r1, f0, r0, 4'h0};
  endfunction

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    gate0 = 1'b1;
    gate1 = 1'b1;
    rxn = 0;
    txn = 0;
    n_mismatch = 0;
    comparisons = 0;
    void'($urandom(32'h76e00a76));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i <= 'h28; i += 4)
      rc(12'(i), 32'h0);
    rc(12'h2c, 32'h0);
    chk(32'(rer), 32'h1);
    // Modes 0 and 1 wrap from all ones
    for (int m = 0; m < 2; m++) begin
      wr(12'h08, m ? 8'hff : 8'h1f);
      wr(12'h0c, 8'hff);
      wr(12'h04, 8'(m));
      wr(12'h00, 8'h10);
      repeat (30) @(posedge clk);
      rc(12'h00, timer_control_register(1'b0, 1'b0, 1'b1, 1'b1));
      rc(12'h0c, 32'h0);
      wr(12'h00, 8'h00);
    end
    // Mode 2 reload drives both baud ticks
    r = 8'($urandom);
    wr(12'h04, 8'h20);
    wr(12'h14, r);
    wr(12'h10, 8'hff);
    rx0 = rxn;
    tx0 = txn;
    wr(12'h00, 8'h40);
    repeat (30) @(posedge clk);
    rc(12'h00, timer_control_register(1'b1, 1'b1, 1'b0, 1'b0));
    rc(12'h14, {24'h0, r});
    chk(32'(rxn > rx0 && txn > tx0), 32'h1);
    wr(12'h04, 8'h30);
    wr(12'h00, 8'h40);
    wr(12'h10, 8'h55);
    repeat (30) @(posedge clk);
    rc(12'h10, 32'h55);
    rc(12'h00, timer_control_register(1'b0, 1'b1, 1'b0, 1'b0));
    wr(12'h00, 8'h00);
    // Each gate pin holds its own timer only
    gate0 <= 1'b0;
    gate1 <= 1'b0;
    wr(12'h08, 8'h00);
    wr(12'h10, 8'h00);
    wr(12'h04, 8'h99);
    wr(12'h00, 8'h50);
    repeat (40) @(posedge clk);
    rc(12'h08, 32'h0);
    gate0 <= 1'b1;
    repeat (40) @(posedge clk);
    apb(1'b0, 12'h08, 32'h0);
    chk(32'(rdv != 0), 32'h1);
    rc(12'h10, 32'h0);
    gate1 <= 1'b1;
    // Counter function at the fastest pin rate
    r = 8'($urandom_range(5, 1));
    wr(12'h00, 8'h00);
    wr(12'h08, 8'h00);
    wr(12'h04, 8'h05);
    wr(12'h00, 8'h10);
    u_src.edges(1'b0, int'(r));
    repeat (40) @(posedge clk);
    rc(12'h08, {24'h0, r});
    wr(12'h00, 8'h00);
    // Timer 0 split: high byte runs on timer 1's run bit and flag
    wr(12'h04, 8'h03);
    wr(12'h08, 8'hff);
    wr(12'h0c, 8'hff);
    wr(12'h00, 8'h40);
    repeat (30) @(posedge clk);
    rc(12'h00, timer_control_register(1'b1, 1'b1, 1'b0, 1'b0));
    rc(12'h08, 32'hff);
    wr(12'h00, 8'h00);
    // Timer 2 reload from capture registers
    r = 8'($urandom);
    wr(12'h24, 8'h00);
    wr(12'h28, r);
    wr(12'h1c, 8'hff);
    wr(12'h20, 8'hff);
    wr(12'h18, 8'h04);
    repeat (30) @(posedge clk);
    rc(12'h18, 32'h84);
    rc(12'h20, {24'h0, r});
    // Capture on trigger, then trigger ignored
    wr(12'h18, 8'h00);
    wr(12'h1c, 8'h5a);
    wr(12'h20, 8'ha5);
    wr(12'h18, 8'h09);
    u_src.edges(1'b1, 1);
    repeat (40) @(posedge clk);
    rc(12'h24, 32'h5a);
    rc(12'h28, 32'ha5);
    rc(12'h18, 32'h49);
    wr(12'h18, 8'h01);
    wr(12'h1c, 8'h00);
    u_src.edges(1'b1, 1);
    repeat (40) @(posedge clk);
    rc(12'h24, 32'h5a);
    rc(12'h18, 32'h01);
    // Trigger reloads in reload mode
    wr(12'h18, 8'h08);
    wr(12'h20, 8'h00);
    u_src.edges(1'b1, 1);
    repeat (40) @(posedge clk);
    rc(12'h20, 32'ha5);
    rc(12'h1c, 32'h5a);
    rc(12'h18, 32'h48);
    // Receive clock from timer 2 with capture select ignored, transmit from stopped timer 1
    wr(12'h24, 8'hff);
    wr(12'h28, 8'hff);
    wr(12'h20, 8'hff);
    wr(12'h1c, 8'hff);
    rx0 = rxn;
    tx0 = txn;
    wr(12'h18, 8'h25);
    repeat (40) @(posedge clk);
    rc(12'h18, 32'h25);
    chk(32'(rxn - rx0 > 1), 32'h1);
    chk(32'(txn - tx0), 32'h0);
    conclude();
  end
endmodule
`default_nettype wire

// ---- sim/ttc_pins.sv ----
// Model of the external count and trigger sources
`timescale 1ns/1ns
`default_nettype none
module ttc_pins (
  input  wire logic clk,
  output var  logic cnt,
  output var  logic trig
);
  initial begin
    cnt = 1'b1;
    trig = 1'b1;
  end
  // Each level held one machine cycle, the fastest legal rate
  task automatic edges(input bit on_trig, input int n);
    repeat (n) begin
      @(posedge clk);
      if (on_trig)
        trig <= 1'b0;
      else
        cnt <= 1'b0;
      repeat (12) @(posedge clk);
      if (on_trig)
        trig <= 1'b1;
      else
        cnt <= 1'b1;
      repeat (11) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// ---- sim/ttc_top_properties.sv ----
// Port checks of the timer unit
`timescale 1ns/1ns
`default_nettype none
module ttc_props #(
  parameter int ADDR_W = 12
) (
  input wire logic              clk,
  input wire logic              rstn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              serial_rx_baud_tick,
  input wire logic              serial_tx_baud_tick
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire logic mapped = (paddr <= 'h28) && (paddr[1:0] == 2'b00);

  a_ready_first: assert property (psel && penable && !$past(penable) |-> pready)
    else $error("pready missing");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  a_err_unmapped: assert property (pready && !mapped |-> pslverr)
    else $error("pslverr missing");
  a_err_mapped: assert property (pready && mapped |-> !pslverr)
    else $error("pslverr spurious");
  a_read_refused: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  a_read_byte: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read upper bits set");
  a_rx_spacing: assert property (serial_rx_baud_tick |=> !serial_rx_baud_tick [*8])
    else $error("rx ticks too close");
  a_tx_spacing: assert property (serial_tx_baud_tick |=> !serial_tx_baud_tick [*8])
    else $error("tx ticks too close");
  a_quiet_start: assert property ($rose(rstn) |-> !serial_rx_baud_tick [*8])
    else $error("tick too soon after reset");

  c_refused: cover property (pready && pslverr);
  c_rx_only: cover property (serial_rx_baud_tick && !serial_tx_baud_tick);
  c_tx: cover property (serial_tx_baud_tick);
endmodule

bind ttc_top ttc_props #(.ADDR_W(ADDR_W)) u_props (.clk(clk), .rstn(rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .serial_rx_baud_tick(serial_rx_baud_tick),
  .serial_tx_baud_tick(serial_tx_baud_tick));
`default_nettype wire
